// ==== design/spvp_port.sv ====
/*
 * spvp_port: serial program/verify port. Commands and 14-bit words move on the
 * programming clock domain; memory, ID words and address counter live on ref_clk.
 * Assumes the programmer holds prog clock/data low when the high level appears,
 * and leaves several ref_clk cycles between a command's end and the next command.
 */
// Behaviour
// R1 - clock and data low while reset pin rises to high level enters program mode; the code enters whenever both are low while the level is high
// R2 - in program mode the clock pin clocks and data pin carries serial data
// R3 - entering program mode clears the address counter to zero
// R4 - programmer sends a six bit command before any data word
// R5 - load commands take a 14-bit word in, read commands drive one out
// R6 - four ID words at 2000h-2003h, reachable only in program mode
// R7 - only the low four bits of each ID word should be used
// R8 - memory reads back through verify unless code protection is programmed
// R9 - bits shift one per clock pulse, least significant bit first
`timescale 1ns/1ps
module spvp_port
    import spvp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              prog_clock_pin,
    input  wire logic              prog_data_pin_i,
    output logic                   prog_data_pin_o,
    output logic                   prog_data_pin_oe,
    input  wire logic              high_programming_level,
    output logic                   prog_mode,
    input  wire logic [MEM_AW-1:0] core_addr,
    output logic [WORD_W-1:0]      core_rdata
);
    // link domain state, clocked by the programming clock
    typedef enum logic [1:0] {
        SPVP_L_CMD,
        SPVP_L_DATA_IN,
        SPVP_L_DATA_OUT
    } spvp_lstate_t;

    logic                  hv_q;
    logic                  mode_q;
    logic                  mode_d;
    logic                  l_mode_s1_q;
    logic                  l_mode_q;
    spvp_lstate_t          l_st_q;
    spvp_lstate_t          l_st_d;
    logic [4:0]            l_cnt_q;
    logic [4:0]            l_cnt_d;
    logic [WORD_W-1:0]     l_sh_q;
    logic [WORD_W-1:0]     l_sh_d;
    spvp_req_t             l_req_q;
    spvp_req_t             l_req_d;
    logic                  l_tog_q;
    logic                  l_tog_d;
    logic                  l_out_q;
    logic                  l_out_d;
    logic                  l_oe_q;
    logic                  l_oe_d;
    logic [WORD_W-1:0]     l_rd_s1_q;
    logic [WORD_W-1:0]     l_rd_q;
    logic [2:0]            c_tog_q;
    logic [2:0]            c_tog_d;
    logic [ADDR_W-1:0]     addr_q;
    logic [ADDR_W-1:0]     addr_d;
    logic [WORD_W-1:0]     latch_q;
    logic [WORD_W-1:0]     latch_d;
    logic [WORD_W-1:0]     rdw_q;
    logic [WORD_W-1:0]     rdw_d;
    logic [WORD_W-1:0]     mem_q [MEM_DEPTH];
    logic [WORD_W-1:0]     id_q  [ID_COUNT];
    logic [WORD_W-1:0]     cfg_q;
    logic [WORD_W-1:0]     cfg_d;
    logic                  c_new;
    spvp_req_t             c_req;
    logic                  is_mem;
    logic                  is_id;
    logic                  protect;

    // mode detect: pin level filtered by three flops
    spvp_sync3 u_hv (
        .clk (ref_clk),
        .rst (rst),
        .d   (high_programming_level),
        .q   (hv_q)
    );
    logic clk_pin_f;
    logic dat_pin_f;
    spvp_sync3 u_ck (
        .clk (ref_clk),
        .rst (rst),
        .d   (prog_clock_pin),
        .q   (clk_pin_f)
    );
    spvp_sync3 u_dt (
        .clk (ref_clk),
        .rst (rst),
        .d   (prog_data_pin_i),
        .q   (dat_pin_f)
    );

    // enter whenever clock and data are low while the level is high; leave when the level drops
    always_comb begin
        mode_d = mode_q;
        if (!hv_q) begin
            mode_d = 1'b0;
        end else if (!mode_q && !clk_pin_f && !dat_pin_f) begin
            mode_d = 1'b1; // R1
        end
    end

    assign prog_mode = mode_q;

    // read word sampled into the link domain; the core holds it still while a read runs
    always_ff @(posedge prog_clock_pin) begin
        l_rd_s1_q <= rdw_q;
        l_rd_q    <= l_rd_s1_q;
    end

    // link shifter: 6-bit command then an optional 14-bit word, lsb first
    always_comb begin
        l_st_d  = l_st_q;
        l_cnt_d = l_cnt_q;
        l_sh_d  = l_sh_q;
        l_req_d = l_req_q;
        l_tog_d = l_tog_q;
        l_out_d = l_out_q;
        l_oe_d  = l_oe_q;
        if (!l_mode_q) begin
            l_st_d  = SPVP_L_CMD;
            l_cnt_d = 5'h00;
            l_oe_d  = 1'b0;
        end else begin
            case (l_st_q)
                SPVP_L_CMD: begin
                    l_sh_d  = {prog_data_pin_i, l_sh_q[WORD_W-1:1]}; // R2 R9
                    l_cnt_d = l_cnt_q + 5'h01;
                    if (l_cnt_q == 5'(CMD_W - 1)) begin // R4
                        l_cnt_d = 5'h00;
                        case (l_sh_d[WORD_W-1 -: CMD_W])
                            CMD_LOAD_DATA, CMD_LOAD_CFG: l_st_d = SPVP_L_DATA_IN;
                            CMD_READ_DATA: begin
                                l_st_d  = SPVP_L_DATA_OUT;
                                l_oe_d  = 1'b1; // R5
                                l_sh_d  = l_rd_q;
                                l_out_d = l_rd_q[0];
                            end
                            CMD_INC_ADDR: begin
                                l_req_d.op = SPVP_OP_INC;
                                l_tog_d    = ~l_tog_q;
                            end
                            CMD_PROG: begin
                                l_req_d.op = SPVP_OP_PROG;
                                l_tog_d    = ~l_tog_q;
                            end
                            default: l_st_d = SPVP_L_CMD;
                        endcase
                    end
                end
                SPVP_L_DATA_IN: begin
                    l_sh_d  = {prog_data_pin_i, l_sh_q[WORD_W-1:1]}; // R5 R9
                    l_cnt_d = l_cnt_q + 5'h01;
                    if (l_cnt_q == 5'(WORD_W - 1)) begin
                        l_st_d       = SPVP_L_CMD;
                        l_cnt_d      = 5'h00;
                        l_req_d.op   = SPVP_OP_LOAD;
                        l_req_d.data = l_sh_d;
                        l_tog_d      = ~l_tog_q;
                    end
                end
                SPVP_L_DATA_OUT: begin
                    l_sh_d  = {1'b0, l_sh_q[WORD_W-1:1]};
                    l_out_d = l_sh_d[0]; // R9
                    l_cnt_d = l_cnt_q + 5'h01;
                    if (l_cnt_q == 5'(WORD_W - 1)) begin
                        l_st_d  = SPVP_L_CMD;
                        l_cnt_d = 5'h00;
                        l_oe_d  = 1'b0;
                    end
                end
                default: l_st_d = SPVP_L_CMD;
            endcase
        end
    end

    // link clock stands still between sessions, so mode low resets the link at once;
    // release is synchronised, hence two idle link edges before the first command bit
    always_ff @(posedge prog_clock_pin or negedge mode_q) begin
        if (!mode_q) begin
            l_mode_s1_q <= 1'b0;
            l_mode_q    <= 1'b0;
            l_st_q      <= SPVP_L_CMD;
            l_cnt_q     <= 5'h00;
            l_sh_q      <= 14'h0000;
            l_req_q     <= '0;
            l_tog_q     <= 1'b0;
            l_out_q     <= 1'b0;
            l_oe_q      <= 1'b0;
        end else begin
            l_mode_s1_q <= 1'b1;
            l_mode_q    <= l_mode_s1_q;
            l_st_q      <= l_st_d;
            l_cnt_q     <= l_cnt_d;
            l_sh_q      <= l_sh_d;
            l_req_q     <= l_req_d;
            l_tog_q     <= l_tog_d;
            l_out_q     <= l_out_d;
            l_oe_q      <= l_oe_d;
        end
    end

    // drive ends with the mode, so a halted clock cannot leave the pin driven
    assign prog_data_pin_o  = l_out_q;
    assign prog_data_pin_oe = l_oe_q & mode_q;

    // core side: toggle crossing, request word stable since before the toggle
    assign c_new   = c_tog_q[2] ^ c_tog_q[1];
    assign c_req   = l_req_q;
    assign is_mem  = (addr_q < ADDR_W'(MEM_DEPTH));
    assign is_id   = (addr_q >= ID_BASE) && (addr_q <= ID_LAST);
    assign protect = ~cfg_q[CP_BIT];

    always_comb begin
        c_tog_d = {c_tog_q[1:0], l_tog_q};
        addr_d  = addr_q;
        latch_d = latch_q;
        cfg_d   = cfg_q;
        if (!mode_q) begin
            addr_d = ADDR_RESET; // R3
        end else if (c_new) begin
            case (c_req.op)
                SPVP_OP_LOAD: latch_d = c_req.data;
                SPVP_OP_INC:  addr_d  = addr_q + 14'h0001;
                SPVP_OP_PROG: if (addr_q == CFG_ADDR) cfg_d = cfg_q & latch_q;
                default:      latch_d = latch_q;
            endcase
        end
        // verify word: memory only while code protection is off
        if (is_mem) begin
            rdw_d = protect ? 14'h0000 : mem_q[addr_q[MEM_AW-1:0]]; // R8
        end else if (is_id) begin
            rdw_d = id_q[addr_q[1:0]]; // R6
        end else if (addr_q == CFG_ADDR) begin
            rdw_d = cfg_q;
        end else begin
            rdw_d = ERASED_WORD;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_q  <= 1'b0;
            c_tog_q <= 3'h0;
            addr_q  <= ADDR_RESET;
            latch_q <= ERASED_WORD;
            rdw_q   <= ERASED_WORD;
            cfg_q   <= ERASED_WORD;
        end else begin
            mode_q  <= mode_d;
            c_tog_q <= c_tog_d;
            addr_q  <= addr_d;
            latch_q <= latch_d;
            rdw_q   <= rdw_d;
            cfg_q   <= cfg_d;
        end
    end

    // one-time programmable cells: programming can only clear bits
    genvar gi;
    generate
        for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    mem_q[gi] <= ERASED_WORD;
                end else if (mode_q && c_new && c_req.op == SPVP_OP_PROG && is_mem
                             && addr_q[MEM_AW-1:0] == MEM_AW'(gi)) begin
                    mem_q[gi] <= mem_q[gi] & latch_q;
                end
            end
        end
        for (gi = 0; gi < ID_COUNT; gi++) begin : g_id
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    id_q[gi] <= ERASED_WORD;
                end else if (mode_q && c_new && c_req.op == SPVP_OP_PROG && is_id
                             && addr_q[1:0] == 2'(gi)) begin
                    id_q[gi] <= id_q[gi] & latch_q; // R6 R7
                end
            end
        end
    endgenerate

    // normal execution sees program memory only; ID words are not mapped here
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_rdata <= 14'h0000;
        end else begin
            core_rdata <= mem_q[core_addr]; // R6
        end
    end

    chk_addr_zero_entry: assert property (@(posedge ref_clk) disable iff (rst) // R3
        $rose(mode_q) |-> addr_q == ADDR_RESET)
        else $error("address not zero on entry");
    chk_entry_pins_low: assert property (@(posedge ref_clk) disable iff (rst) // R1
        $rose(mode_q) |-> $past(!clk_pin_f && !dat_pin_f && hv_q))
        else $error("mode entered without pins low");
    chk_mode_drops_hv: assert property (@(posedge ref_clk) disable iff (rst) // R1
        !hv_q |=> !mode_q)
        else $error("mode held without high level");
    chk_drive_in_mode: assert property (@(posedge ref_clk) disable iff (rst) // R5
        l_oe_q |-> mode_q)
        else $error("data pin driven outside mode");
    chk_protect_hides: assert property (@(posedge ref_clk) disable iff (rst) // R8
        protect && is_mem |=> rdw_q == 14'h0000)
        else $error("protected memory read out");
    chk_verify_open: assert property (@(posedge ref_clk) disable iff (rst) // R8
        !protect && is_mem && $stable(addr_q) |=> rdw_q == $past(mem_q[addr_q[MEM_AW-1:0]]))
        else $error("unprotected memory not verifiable");
    chk_id_readback: assert property (@(posedge ref_clk) disable iff (rst) // R6
        is_id |=> rdw_q == $past(id_q[addr_q[1:0]]))
        else $error("id word not returned");
    chk_inc_step: assert property (@(posedge ref_clk) disable iff (rst) // R4
        mode_q && c_new && c_req.op == SPVP_OP_INC |=> addr_q == $past(addr_q) + 14'h0001)
        else $error("increment not applied");
    chk_out_mode_only: assert property (@(posedge ref_clk) disable iff (rst) // R3
        !mode_q |=> addr_q == ADDR_RESET)
        else $error("address kept outside mode");
endmodule

// ==== design/spvp_pkg.sv ====
/*
 * spvp_pkg: constants and carrier types for the serial program/verify port.
 * Assumes a core clock of 125 MHz; the programming clock is a separate domain.
 */
package spvp_pkg;
    localparam int CMD_W      = 6;
    localparam int WORD_W     = 14;
    localparam int ADDR_W     = 14;
    localparam int MEM_DEPTH  = 1024;
    localparam int MEM_AW     = 10;
    localparam int ID_COUNT   = 4;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
    localparam logic [ADDR_W-1:0] ID_BASE    = 14'h2000;
    localparam logic [ADDR_W-1:0] ID_LAST    = 14'h2003;
    localparam logic [ADDR_W-1:0] CFG_ADDR   = 14'h2007;
    // command encodings are not given; neutral values chosen here
    localparam logic [CMD_W-1:0] CMD_LOAD_CFG  = 6'h00;
    localparam logic [CMD_W-1:0] CMD_LOAD_DATA = 6'h02;
    localparam logic [CMD_W-1:0] CMD_READ_DATA = 6'h04;
    localparam logic [CMD_W-1:0] CMD_INC_ADDR  = 6'h06;
    localparam logic [CMD_W-1:0] CMD_PROG      = 6'h08;
    localparam logic [WORD_W-1:0] ERASED_WORD  = 14'h3fff;
    localparam int CP_BIT = 4;          // code protect bit of config word, 0 = protected

    typedef enum logic [1:0] {
        SPVP_OP_LOAD,
        SPVP_OP_READ,
        SPVP_OP_INC,
        SPVP_OP_PROG
    } spvp_op_t;

    // a command finished on the link, handed to the core domain
    typedef struct packed {
        spvp_op_t           op;
        logic [WORD_W-1:0]  data;
    } spvp_req_t;
endpackage

// ==== design/spvp_sync3.sv ====
/*
 * spvp_sync3: three flop input filter; output changes when stages two and three agree.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
module spvp_sync3 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic [2:0] s_q;
    logic [2:0] s_d;
    logic       q_d;

    // s_q[0] feeds only s_q[1]
    always_comb begin
        s_d = {s_q[1:0], d};
        q_d = (s_q[1] == s_q[2]) ? s_q[2] : q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= 3'h0;
            q   <= 1'b0;
        end else begin
            s_q <= s_d;
            q   <= q_d;
        end
    end
endmodule

// ==== dv/spvp_programmer.sv ====
/*
 * spvp_programmer: behavioural programmer for the serial program/verify port.
 * Assumes the bench resolves the data wire from the device's enable alone and drives the high level itself.
 */
`timescale 1ns/1ps
module spvp_programmer (
    output logic      clk_o,
    output logic      data_o,
    input  wire logic data_i,
    input  wire logic oe_i
);
    real half = 3.0;
    // clock stands low outside frames, pins low before entry
    initial begin
        clk_o = 1'b0;
        data_o = 1'b0;
    end
    // pin levels around entry, also used to break the entry condition
    task automatic hold(input logic c, input logic d);
        clk_o = c;
        data_o = d;
    endtask
    // data moves only while the clock is low, so it is stable across the rising edge
    task automatic shift_bit(input logic b);
        data_o = b;
        #(half) clk_o = 1'b1;
        #(half) clk_o = 1'b0;
    endtask
    task automatic send_cmd(input logic [5:0] c);
        for (int i = 0; i < 6; i++) shift_bit(c[i]);
    endtask
    task automatic send_word(input logic [13:0] w);
        for (int i = 0; i < 14; i++) shift_bit(w[i]);
        data_o = ~w[13]; // released line shows the inverse, never the held bit
    endtask
    // read phase: sample each bit while the clock is low, before the edge that advances it
    task automatic recv(output logic [13:0] w, output logic all_oe);
        all_oe = 1'b1;
        data_o = ~data_o;
        for (int i = 0; i < 14; i++) begin
            w[i] = data_i;
            all_oe = all_oe & oe_i;
            #(half) clk_o = 1'b1;
            #(half) clk_o = 1'b0;
        end
    endtask
endmodule

// ==== dv/tb_serial_program_verify_port.sv ====
/*
 * tb_serial_program_verify_port: self-checking bench for spvp_port.
 * Assumes the programmer model owns the link pins; the bench drives reset, level and fetch address.
 */
`timescale 1ns/1ps
module tb_serial_program_verify_port;
    import spvp_pkg::*;
    logic              ref_clk    = 1'b0;
    logic              rst        = 1'b1;
    logic              lvl        = 1'b0;
    logic [MEM_AW-1:0] core_addr  = '0;
    logic [WORD_W-1:0] core_rdata;
    logic              pclk;
    logic              pdat_m;
    logic              dat_o;
    logic              dat_oe;
    logic              prog_mode;
    logic              data_wire;
    logic              all_oe;
    logic [WORD_W-1:0] w0;
    logic [WORD_W-1:0] w1;
    logic [WORD_W-1:0] idv;
    logic [WORD_W-1:0] rd;
    int                n_mismatch = 0;
    int                n_compared = 0;

    always #4 ref_clk = ~ref_clk;
    // device owns the wire while enabled, else the programmer's level
    assign data_wire = dat_oe ? dat_o : pdat_m;

    spvp_programmer prog_u (.clk_o(pclk), .data_o(pdat_m), .data_i(data_wire), .oe_i(dat_oe));
    spvp_port dut_u (.ref_clk(ref_clk), .rst(rst), .prog_clock_pin(pclk), .prog_data_pin_i(data_wire),
        .prog_data_pin_o(dat_o), .prog_data_pin_oe(dat_oe), .high_programming_level(lvl),
        .prog_mode(prog_mode), .core_addr(core_addr), .core_rdata(core_rdata));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one-time cells can only clear bits
    function automatic logic [WORD_W-1:0] burn(input logic [WORD_W-1:0] old, input logic [WORD_W-1:0] w);
        return old & w;
    endfunction
    task automatic gap(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic set_level(input logic v);
        @(posedge ref_clk) lvl <= v;
        for (int i = 0; i < 40 && prog_mode !== v; i++) @(posedge ref_clk);
        check(prog_mode, v);
    endtask
    // mode crossing needs two idle link edges before the first command bit
    task automatic enter();
        prog_u.hold(1'b0, 1'b0);
        gap(4); // pin filters must see both pins low before the level rises
        set_level(1'b1);
        prog_u.shift_bit(1'b0);
        prog_u.shift_bit(1'b0);
    endtask
    task automatic cmd(input logic [CMD_W-1:0] c);
        prog_u.send_cmd(c);
        gap(3); // command ends stay at least six core cycles apart
    endtask
    task automatic load_prog(input logic [WORD_W-1:0] w);
        prog_u.send_cmd(CMD_LOAD_DATA);
        prog_u.send_word(w);
        gap(3);
        cmd(CMD_PROG);
    endtask
    task automatic read_chk(input logic [WORD_W-1:0] exp);
        gap(12); // read path follows the address only after it has settled
        prog_u.send_cmd(CMD_READ_DATA);
        prog_u.recv(rd, all_oe);
        gap(3);
        check(rd, exp);
        check(all_oe, 1'b1);
        check(dat_oe, 1'b0);
    endtask
    task automatic fetch(input logic [MEM_AW-1:0] a, input logic [WORD_W-1:0] exp);
        @(posedge ref_clk) core_addr <= a;
        gap(3);
        check(core_rdata, exp);
    endtask

    // watchdog: the increment walk to the ID words dominates the run
    initial begin
        #700_000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        void'($urandom(18950));
        w0 = WORD_W'($urandom);
        w1 = WORD_W'($urandom);
        gap(8);
        rst <= 1'b0;
        gap(2);
        check(prog_mode, 1'b0);
        fetch(10'h000, ERASED_WORD);
        // entry refused with the clock high, then with the data pin high
        for (int k = 0; k < 2; k++) begin
            prog_u.hold(k == 0, k == 1);
            @(posedge ref_clk) lvl <= 1'b1;
            gap(10);
            check(prog_mode, 1'b0);
            @(posedge ref_clk) lvl <= 1'b0;
            gap(4);
        end
        enter();
        read_chk(ERASED_WORD);
        load_prog(w0);
        read_chk(burn(ERASED_WORD, w0));
        load_prog(14'h3fff);
        read_chk(burn(ERASED_WORD, w0));
        cmd(CMD_INC_ADDR);
        load_prog(w1);
        prog_u.half = 7.0; // a slow programmer for one read
        read_chk(burn(ERASED_WORD, w1));
        prog_u.half = 3.0;
        set_level(1'b0);
        fetch(10'h000, w0);
        fetch(10'h001, w1);
        enter();
        read_chk(w0);
        for (int i = 0; i < 32'h2000; i++) cmd(CMD_INC_ADDR);
        read_chk(ERASED_WORD);
        idv = {10'h000, 4'($urandom)};
        load_prog(idv);
        read_chk(idv);
        repeat (3) cmd(CMD_INC_ADDR);
        load_prog(14'h3ff5);
        read_chk(14'h3ff5);
        cmd(6'h3f);
        cmd(CMD_INC_ADDR);
        read_chk(ERASED_WORD);
        repeat (3) cmd(CMD_INC_ADDR);
        // config word through the config load code; clearing its protect bit hides memory from verify
        prog_u.send_cmd(CMD_LOAD_CFG);
        prog_u.send_word(ERASED_WORD ^ (14'h0001 << CP_BIT));
        gap(3);
        cmd(CMD_PROG);
        read_chk(ERASED_WORD ^ (14'h0001 << CP_BIT));
        set_level(1'b0);
        fetch(10'h000, w0);
        enter();
        read_chk(14'h0000);
        end_of_test();
    end
endmodule
